// *** hw/clock_divider.sv ***
// Oscillator divider: CPU tick, system clock out, serial bit tick
`timescale 1ns/100ps
`default_nettype none
module clock_divider
  import core_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // Controls
  input  wire logic slow_variant_i,
  input  wire logic halted_i,
  // Outputs
  output logic      cpu_tick_o,
  output logic      sys_clk_o,
  output logic      serial_bit_tick_o
);
  logic [2:0] div_q;

  // Free-running divider of the oscillator
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  // CPU tick every fourth edge, stopped in halt
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_tick_o <= 1'b0;
    end else begin
      cpu_tick_o <= (div_q[1:0] == 2'(CPU_DIV - 1)) && !halted_i;
    end
  end

  // System clock pin, divided by four or eight
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sys_clk_o <= 1'b0;
    end else begin
      sys_clk_o <= slow_variant_i ? div_q[2] : div_q[1];
    end
  end

  // Serial counter keeps ticking in every mode here; core_regs gates the pin tick out in stop
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_bit_tick_o <= 1'b0;
    end else begin
      serial_bit_tick_o <= (div_q == SERIAL_DIV_MAX);
    end
  end
endmodule
`default_nettype wire

// *** hw/core_pkg.sv ***
// Shared constants for the 8-bit core datapath and its register bus
package core_pkg;
  // Avalon-MM register word offsets (byte addresses)
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_OPERAND  = 8'h04;
  localparam logic [7:0] OFS_ACC      = 8'h08;
  localparam logic [7:0] OFS_PC       = 8'h0c;
  localparam logic [7:0] OFS_SP       = 8'h10;
  localparam logic [7:0] OFS_PAIRS    = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;
  localparam logic [7:0] OFS_ADDR     = 8'h1c;
  localparam logic [7:0] OFS_SFR      = 8'h20;
  localparam logic [7:0] OFS_MODE     = 8'h24;
  // Reset values
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [15:0] SP_RESET    = 16'h0000;
  localparam logic [7:0]  PAGE_REG    = 8'hff;
  localparam logic [7:0]  MODEB_RESET = 8'hff;
  // Fixed area and call table
  localparam logic [4:0]  FIXED_AREA_HI  = 5'h00;
  localparam logic [15:0] CALL_TABLE_BASE = 16'h0080;
  // Clock divisions
  localparam int CPU_DIV      = 4;
  localparam int OUT_DIV_SLOW = 8;
  localparam logic [2:0] SERIAL_DIV_MAX = 3'h7;
  // Command opcodes (low 5 bits of command word)
  localparam logic [4:0] OP_NOP   = 5'h00;
  localparam logic [4:0] OP_STEP  = 5'h01;
  localparam logic [4:0] OP_JMP   = 5'h02;
  localparam logic [4:0] OP_ALU   = 5'h03;
  localparam logic [4:0] OP_INDIR = 5'h04;
  localparam logic [4:0] OP_WORK  = 5'h05;
  localparam logic [4:0] OP_DIRECT= 5'h06;
  localparam logic [4:0] OP_CALL  = 5'h07;
  localparam logic [4:0] OP_SCALL = 5'h08;
  localparam logic [4:0] OP_TCALL = 5'h09;
  localparam logic [4:0] OP_RET   = 5'h0a;
  localparam logic [4:0] OP_PUSH  = 5'h0b;
  localparam logic [4:0] OP_POP   = 5'h0c;
  localparam logic [4:0] OP_MOVR  = 5'h0d;
  localparam logic [4:0] OP_SFRW  = 5'h0e;
  localparam logic [4:0] OP_SFRR  = 5'h0f;
  localparam logic [4:0] OP_SFRI  = 5'h10;
  localparam logic [4:0] OP_HALT  = 5'h11;
  localparam logic [4:0] OP_STOP  = 5'h12;
  localparam logic [4:0] OP_WAKE  = 5'h13;
  localparam logic [4:0] OP_LXI   = 5'h14;
  localparam logic [4:0] OP_FLAG  = 5'h15;
  // Arithmetic kinds
  localparam logic [2:0] ALU_ADD = 3'h0;
  localparam logic [2:0] ALU_ADC = 3'h1;
  localparam logic [2:0] ALU_SUB = 3'h2;
  localparam logic [2:0] ALU_SBB = 3'h3;
  localparam logic [2:0] ALU_ADD_SKIP_NO_CARRY = 3'h4;
  localparam logic [2:0] ALU_SUBTRACT_SKIP_NO_BORROW = 3'h5;
  // Indirect field encodings
  localparam logic [2:0] IND_P1 = 3'h1;
  localparam logic [2:0] IND_P2 = 3'h2;
  localparam logic [2:0] IND_P3 = 3'h3;
  localparam logic [2:0] IND_P2_INC = 3'h4;
  localparam logic [2:0] IND_P3_INC = 3'h5;
  localparam logic [2:0] IND_P2_DEC = 3'h6;
  localparam logic [2:0] IND_P3_DEC = 3'h7;
  // Special register selects
  localparam logic [3:0] SR_PA = 4'h0;
  localparam logic [3:0] SR_PB = 4'h1;
  localparam logic [3:0] SR_PC = 4'h2;
  localparam logic [3:0] SR_MK = 4'h3;
  localparam logic [3:0] SR_MB = 4'h4;
  localparam logic [3:0] SR_TM0 = 4'h5;
  localparam logic [3:0] SR_TM1 = 4'h6;
  localparam logic [3:0] SR_S  = 4'h7;
  localparam logic [3:0] SR_SM = 4'h8;
  localparam logic [3:0] SR_SC = 4'h9;
  localparam int SR_COUNT = 10;
  // Mode encodings
  typedef enum logic [2:0] {
    RUN_ST  = 3'b001,
    HALT_ST = 3'b010,
    STOP_ST = 3'b100
  } run_state_e;
endpackage

// *** hw/core_regs.sv ***
// Core register set, addressing unit and operand decode
`timescale 1ns/100ps
`default_nettype none
module core_regs
  import core_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // External data path, accumulator only
  input  wire logic [7:0]  ext_data_i,
  output logic [15:0]      mem_addr_o,
  output logic [7:0]       mem_wdata_o,
  output logic             mem_we_o,
  // Pins
  input  wire logic        slow_variant_i,
  output logic             sys_clk_o,
  output logic             serial_bit_tick_o
);
  // Architectural state
  logic [15:0] program_counter_q;
  logic [15:0] stack_pointer_q;
  logic [7:0]  acc_q;
  logic [7:0]  gpr_q [6];
  logic        carry_flag_q;
  logic        zero_flag_q;
  logic        skip_q;
  logic [7:0]  sfr_q [SR_COUNT];
  logic [3:0]  pending_request_flags_q;
  logic [15:0] addr_q;
  logic [31:0] cmd_q;
  logic [15:0] operand_q;
  logic        pend_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  run_state_e  run_q;
  logic        cpu_tick;
  logic        sys_clk;
  logic        ser_tick;
  logic        slow_s1_q;
  logic        slow_s2_q;
  logic        ld_q;

  // Strap synchroniser
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slow_s1_q <= 1'b0;
      slow_s2_q <= 1'b0;
    end else begin
      slow_s1_q <= slow_variant_i;
      slow_s2_q <= slow_s1_q;
    end
  end

  clock_divider u_div (
    .core_clk_i        (core_clk_i),
    .rst_n_i           (rst_n_i),
    .slow_variant_i    (slow_s2_q),
    .halted_i          (run_q != RUN_ST),
    .cpu_tick_o        (cpu_tick),
    .sys_clk_o         (sys_clk),
    .serial_bit_tick_o (ser_tick)
  );

  // Pair read helper: 0 first, 1 second, 2 third, 3 stack
  function automatic logic [15:0] pair_rd(input logic [1:0] sel,
                                          input logic [15:0] sp,
                                          input logic [7:0] g [6]);
    case (sel)
      2'd0:    pair_rd = {g[0], g[1]};
      2'd1:    pair_rd = {g[2], g[3]};
      2'd2:    pair_rd = {g[4], g[5]};
      default: pair_rd = sp;
    endcase
  endfunction

  // Indirect code to pair index
  function automatic logic [1:0] ind_pair(input logic [2:0] code);
    case (code)
      IND_P1:                         ind_pair = 2'd0;
      IND_P2, IND_P2_INC, IND_P2_DEC: ind_pair = 2'd1;
      default:                        ind_pair = 2'd2;
    endcase
  endfunction

  // Command fields
  logic [4:0]  op;
  logic [2:0]  sub;
  logic [3:0]  sel;
  logic [7:0]  imm;
  logic [15:0] word;
  logic        exec;
  assign op   = cmd_q[4:0];
  assign sub  = cmd_q[10:8];
  assign sel  = cmd_q[15:12];
  assign imm  = operand_q[7:0];
  assign word = operand_q;
  assign exec = pend_q && cpu_tick && (run_q == RUN_ST);

  // Operand address generation
  logic [15:0] ea;
  always_comb begin
    ea = addr_q;
    case (op)
      OP_INDIR: ea = pair_rd(ind_pair(sub), stack_pointer_q, gpr_q);
      OP_WORK:  ea = {PAGE_REG, imm};
      OP_DIRECT: ea = {word[15:8], word[7:0]};
      default:  ea = addr_q;
    endcase
  end

  // Arithmetic unit
  logic [8:0] sum;
  logic       skip_cond;
  always_comb begin
    case (sub)
      ALU_ADD, ALU_ADD_SKIP_NO_CARRY: sum = {1'b0, acc_q} + {1'b0, imm};
      ALU_ADC: sum = {1'b0, acc_q} + {1'b0, imm} + {8'h00, carry_flag_q};
      ALU_SUB, ALU_SUBTRACT_SKIP_NO_BORROW: sum = {1'b0, acc_q} - {1'b0, imm};
      ALU_SBB: sum = {1'b0, acc_q} - {1'b0, imm} - {8'h00, carry_flag_q};
      default: sum = {1'b0, acc_q};
    endcase
    skip_cond = ((sub == ALU_ADD_SKIP_NO_CARRY) || (sub == ALU_SUBTRACT_SKIP_NO_BORROW)) && !sum[8];
  end

  // Avalon slave: one wait cycle, then answer
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= (avs_read_i || avs_write_i) && !ack_q;
      case (avs_address_i)
        OFS_CMD:     rdata_q <= cmd_q;
        OFS_OPERAND: rdata_q <= {16'h0, operand_q};
        OFS_ACC:     rdata_q <= {24'h0, acc_q};
        OFS_PC:      rdata_q <= {16'h0, program_counter_q};
        OFS_SP:      rdata_q <= {16'h0, stack_pointer_q};
        OFS_PAIRS:   rdata_q <= {8'h0, gpr_q[0], gpr_q[2], gpr_q[4]};
        OFS_STATUS:  rdata_q <= {20'h0, pending_request_flags_q,
                                 run_q, skip_q, zero_flag_q, carry_flag_q,
                                 pend_q, 1'b0};
        OFS_ADDR:    rdata_q <= {16'h0, addr_q};
        OFS_SFR:     rdata_q <= {24'h0, sfr_q[sel]};
        OFS_MODE:    rdata_q <= {24'h0, gpr_q[1]};
        default:     rdata_q <= 32'h0;
      endcase
    end
  end
  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = !ack_q;

  // Command and operand registers; completion clears pending
  logic wr_cmd;
  assign wr_cmd = avs_write_i && ack_q && (avs_address_i == OFS_CMD);
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_q     <= 32'h0;
      operand_q <= 16'h0;
      pend_q    <= 1'b0;
    end else begin
      if (wr_cmd) begin
        cmd_q  <= avs_writedata_i;
        pend_q <= 1'b1;
      end else if (exec || (pend_q && op == OP_WAKE)) begin
        pend_q <= 1'b0;
      end
      if (avs_write_i && ack_q && avs_address_i == OFS_OPERAND) begin
        operand_q <= avs_writedata_i[15:0];
      end
    end
  end

  // Run, halt and stop state
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q <= RUN_ST;
    end else begin
      case (run_q)
        RUN_ST:  if (exec && op == OP_HALT) run_q <= HALT_ST;
                 else if (exec && op == OP_STOP) run_q <= STOP_ST;
        HALT_ST, STOP_ST: if (pend_q && op == OP_WAKE) run_q <= RUN_ST;
        default: run_q <= RUN_ST;
      endcase
    end
  end

  // Program counter
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      program_counter_q <= PC_RESET;
    end else if (exec && op == OP_STOP) begin
      program_counter_q <= PC_RESET;
    end else if (exec) begin
      case (op)
        OP_JMP:   program_counter_q <= sub[0] ?
                    {gpr_q[0], gpr_q[1]} : word;
        OP_CALL:  program_counter_q <= word;
        OP_SCALL: program_counter_q <= {FIXED_AREA_HI,
                    1'b0, word[9:0]};
        OP_TCALL: program_counter_q <= CALL_TABLE_BASE +
                    {10'h0, word[4:0], 1'b0};
        OP_ALU:   program_counter_q <= program_counter_q +
                    (skip_cond ? 16'h2 : 16'h1);
        default:  program_counter_q <= program_counter_q + 16'h1;
      endcase
    end
  end

  // Stack pointer
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stack_pointer_q <= SP_RESET;
    end else if (exec) begin
      case (op)
        OP_CALL, OP_SCALL, OP_TCALL, OP_PUSH:
          stack_pointer_q <= stack_pointer_q - 16'h2;
        OP_RET, OP_POP:
          stack_pointer_q <= stack_pointer_q + 16'h2;
        OP_LXI:
          if (sel[1:0] == 2'd3) stack_pointer_q <= word;
        default: stack_pointer_q <= stack_pointer_q;
      endcase
    end
  end

  // General registers, pair loads and auto-step
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 6; i++) gpr_q[i] <= 8'h00;
    end else if (exec) begin
      case (op)
        OP_MOVR: gpr_q[sel[2:0] % 6] <= acc_q;
        OP_LXI, OP_POP: if (sel[1:0] != 2'd3) begin
          gpr_q[{sel[1:0], 1'b0}]  <= word[15:8];
          gpr_q[{sel[1:0], 1'b1}]  <= word[7:0];
        end
        OP_INDIR: begin
          if (sub == IND_P2_INC) {gpr_q[2], gpr_q[3]} <= {gpr_q[2], gpr_q[3]} + 16'h1;
          if (sub == IND_P3_INC) {gpr_q[4], gpr_q[5]} <= {gpr_q[4], gpr_q[5]} + 16'h1;
          if (sub == IND_P2_DEC) {gpr_q[2], gpr_q[3]} <= {gpr_q[2], gpr_q[3]} - 16'h1;
          if (sub == IND_P3_DEC) {gpr_q[4], gpr_q[5]} <= {gpr_q[4], gpr_q[5]} - 16'h1;
        end
        default: gpr_q[0] <= gpr_q[0];
      endcase
    end
  end

  // Accumulator, flags and external transfers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q <= 8'h00; carry_flag_q <= 1'b0; zero_flag_q <= 1'b0;
      skip_q <= 1'b0; addr_q <= 16'h0; mem_we_o <= 1'b0;
      mem_wdata_o <= 8'h00; ld_q <= 1'b0;
    end else begin
      mem_we_o <= 1'b0;
      ld_q <= 1'b0;
      // Load lands once the new address has reached memory
      if (ld_q) acc_q <= ext_data_i;
      if (exec && op == OP_STOP) begin
        carry_flag_q <= 1'b0; zero_flag_q <= 1'b0; skip_q <= 1'b0;
      end else if (exec) begin
        case (op)
          OP_ALU: begin
            acc_q <= sum[7:0];
            carry_flag_q <= sum[8];
            zero_flag_q <= (sum[7:0] == 8'h00);
            skip_q <= skip_cond;
          end
          OP_INDIR, OP_WORK, OP_DIRECT: begin
            addr_q <= ea;
            if (sub[0] && op != OP_INDIR || cmd_q[16]) begin
              mem_we_o <= 1'b1; mem_wdata_o <= acc_q;
            end else begin
              ld_q <= 1'b1;
            end
          end
          OP_SFRR: if (sel != SR_MB && sel != SR_SM)
                     acc_q <= sfr_q[sel];
          default: acc_q <= acc_q;
        endcase
      end
    end
  end
  assign mem_addr_o = addr_q;

  // Special registers and request flags
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < SR_COUNT; i++) sfr_q[i] <= 8'h00;
      sfr_q[SR_MB] <= MODEB_RESET;
      pending_request_flags_q <= 4'h0;
    end else if (exec) begin
      case (op)
        OP_SFRW: if (sel < 4'(SR_COUNT)) sfr_q[sel] <= acc_q;
        OP_SFRI: if (sel <= SR_MK) sfr_q[sel] <= sfr_q[sel] | imm;
        OP_FLAG: pending_request_flags_q[sel[1:0]] <= 1'b0;
        OP_STOP: pending_request_flags_q <= 4'h0;
        default: pending_request_flags_q <= pending_request_flags_q;
      endcase
    end
  end

  // Pin outputs registered; serial tick gated out in stop
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sys_clk_o <= 1'b0; serial_bit_tick_o <= 1'b0;
    end else begin
      sys_clk_o <= sys_clk;
      serial_bit_tick_o <= ser_tick && (run_q != STOP_ST);
    end
  end

  // Checks
  AST_PC_STOP: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    exec && op == OP_STOP |=> program_counter_q == 16'h0)
    else $error("stop did not clear counter");
  AST_HALT_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    run_q == HALT_ST |=> $stable(program_counter_q))
    else $error("counter moved in halt");
  AST_SP_CALL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    exec && op == OP_CALL |=> stack_pointer_q == $past(stack_pointer_q) - 16'h2)
    else $error("call did not drop stack");
  AST_WORK_PAGE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    exec && op == OP_WORK |=> mem_addr_o[15:8] == 8'hff)
    else $error("page not all ones");
  AST_SCALL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    exec && op == OP_SCALL |=> program_counter_q < 16'h0800)
    else $error("short call outside area");
  AST_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    exec && op == OP_ALU |=> zero_flag_q == (acc_q == 8'h00))
    else $error("zero flag mismatch");
  AST_TICK: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cpu_tick |=> !cpu_tick [*3])
    else $error("cpu tick too fast");
  AST_STOP_TICK: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    run_q == STOP_ST |=> !serial_bit_tick_o)
    else $error("serial tick leaked in stop");
  COV_ALU: cover property (@(posedge core_clk_i) exec && op == OP_ALU);
  COV_HALT: cover property (@(posedge core_clk_i) run_q == HALT_ST);
  COV_INC: cover property (@(posedge core_clk_i) exec && sub == IND_P2_INC);
endmodule
`default_nettype wire

// *** sim/cpu_core_registers_addressing_test.sv ***
// Self-checking bench for the core register set and addressing unit
`timescale 1ns/100ps
`default_nettype none
module cpu_core_registers_addressing_test
  import core_pkg::*;
;
  logic core_clk_i, rst_n_i, avs_read, avs_write, avs_wait, mem_we, slow;
  logic sys_clk, ser_tick;
  logic [7:0] avs_address, ext_data, mem_wdata;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [15:0] mem_addr;
  int n_fail = 0;
  int cmp_count = 0;

  core_regs dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_wait),
    .ext_data_i(ext_data), .mem_addr_o(mem_addr),
    .mem_wdata_o(mem_wdata), .mem_we_o(mem_we),
    .slow_variant_i(slow), .sys_clk_o(sys_clk),
    .serial_bit_tick_o(ser_tick));

  ext_memory_model mem (
    .core_clk_i(core_clk_i), .mem_addr_i(mem_addr),
    .mem_wdata_i(mem_wdata), .mem_we_i(mem_we), .ext_data_o(ext_data));

  // Clock at 200 MHz
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One Avalon-MM access, held until waitrequest is sampled low
  task automatic av_xfer(input logic wr, input logic [7:0] a,
                         input logic [31:0] d);
    int i;
    @(posedge core_clk_i);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    i = 0;
    do begin
      @(posedge core_clk_i);
      i++;
    end while (avs_wait !== 1'b0 && i < 100);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (i >= 100) begin
      n_fail++;
      complete_run();
    end
  endtask

  // Operand, then command, then poll the pending flag
  task automatic run_cmd(input logic [31:0] cmd, input logic [31:0] opnd);
    int i;
    av_xfer(1'b1, OFS_OPERAND, opnd);
    av_xfer(1'b1, OFS_CMD, cmd);
    i = 0;
    do begin
      av_xfer(1'b0, OFS_STATUS, 32'h0);
      i++;
    end while (rd[1] !== 1'b0 && i < 50);
    if (i >= 50) begin
      n_fail++;
      complete_run();
    end
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] msk, input logic [31:0] e);
    av_xfer(1'b0, a, 32'h0);
    check(nm, e, rd & msk);
  endtask

  task automatic t_reset();
    rd_chk("pc", OFS_PC, 32'hffff, {16'h0, PC_RESET});
    rd_chk("run", OFS_STATUS, 32'he0, {24'h0, RUN_ST, 5'h0});
    rd_chk("unmapped", 8'h30, 32'hffffffff, 32'h0);
    check("mem_we", 32'h0, {31'h0, mem_we});
    $display("test reset done");
  endtask

  task automatic t_flow();
    run_cmd({27'h0, OP_JMP}, 32'h1234);
    rd_chk("jmp pc", OFS_PC, 32'hffff, 32'h1234);
    run_cmd({27'h0, OP_STEP}, 32'h0);
    rd_chk("step pc", OFS_PC, 32'hffff, 32'h1235);
    $display("test flow done");
  endtask

  task automatic t_addr();
    run_cmd({27'h0, OP_WORK}, 32'h34);
    check("work addr", {16'h0, PAGE_REG, 8'h34}, {16'h0, mem_addr});
    run_cmd({27'h0, OP_DIRECT}, 32'hbeef);
    check("direct addr", 32'hbeef, {16'h0, mem_addr});
    run_cmd({16'h0, 4'h1, 7'h0, OP_LXI}, 32'h2000);
    run_cmd({21'h0, IND_P2_INC, 3'h0, OP_INDIR}, 32'h0);
    check("ind addr", 32'h2000, {16'h0, mem_addr});
    rd_chk("ind acc", OFS_ACC, 32'hff, 32'ha5);
    run_cmd({21'h0, IND_P2_INC, 3'h0, OP_INDIR}, 32'h0);
    check("inc addr", 32'h2001, {16'h0, mem_addr});
    $display("test addressing done");
  endtask

  task automatic t_alu();
    run_cmd({27'h0, OP_WORK}, 32'h5a);
    rd_chk("load acc", OFS_ACC, 32'hff, 32'hff);
    run_cmd({21'h0, ALU_ADD, 3'h0, OP_ALU}, 32'h01);
    rd_chk("add acc", OFS_ACC, 32'hff, 32'h00);
    rd_chk("add flags", OFS_STATUS, 32'h0c, 32'h0c);
    run_cmd({21'h0, ALU_ADD_SKIP_NO_CARRY, 3'h0, OP_ALU}, 32'h01);
    rd_chk("add_skip_no_carry acc", OFS_ACC, 32'hff, 32'h01);
    rd_chk("add_skip_no_carry skip", OFS_STATUS, 32'h14, 32'h10);
    $display("test arithmetic done");
  endtask

  task automatic t_call();
    run_cmd({27'h0, OP_TCALL}, 32'h1f);
    rd_chk("tcall pc", OFS_PC, 32'hffff, 32'h00be);
    rd_chk("call sp", OFS_SP, 32'hffff, {16'h0, SP_RESET - 16'h2});
    run_cmd({27'h0, OP_RET}, 32'h0);
    rd_chk("ret sp", OFS_SP, 32'hffff, {16'h0, SP_RESET});
    run_cmd({27'h0, OP_SCALL}, 32'h2a5);
    rd_chk("scall pc", OFS_PC, 32'hffff, 32'h02a5);
    $display("test call done");
  endtask

  task automatic t_modes();
    run_cmd({27'h0, OP_JMP}, 32'h0100);
    run_cmd({27'h0, OP_HALT}, 32'h0);
    rd_chk("halt st", OFS_STATUS, 32'he0, {24'h0, HALT_ST, 5'h0});
    rd_chk("halt pc", OFS_PC, 32'hffff, 32'h0101);
    run_cmd({27'h0, OP_WAKE}, 32'h0);
    run_cmd({27'h0, OP_STOP}, 32'h0);
    rd_chk("stop st", OFS_STATUS, 32'he0, {24'h0, STOP_ST, 5'h0});
    rd_chk("stop pc", OFS_PC, 32'hffff, 32'h0);
    run_cmd({27'h0, OP_WAKE}, 32'h0);
    rd_chk("wake st", OFS_STATUS, 32'he0, {24'h0, RUN_ST, 5'h0});
    $display("test modes done");
  endtask

  // Count rising edges of the clock outputs over 64 cycles
  task automatic t_clocks(input logic s, input int exp_sys);
    int ns, nt;
    logic ps;
    @(posedge core_clk_i);
    slow <= s;
    repeat (32) @(posedge core_clk_i);
    ns = 0;
    nt = 0;
    ps = sys_clk;
    repeat (64) begin
      @(posedge core_clk_i);
      if (sys_clk === 1'b1 && ps === 1'b0) ns++;
      if (ser_tick === 1'b1) nt++;
      ps = sys_clk;
    end
    check("sys_clk edges", exp_sys, ns);
    check("serial ticks", 32'd8, nt);
    $display("test clocks done");
  endtask

  // Main sequence
  initial begin
    rst_n_i       = 1'b0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_address   = 8'h00;
    avs_writedata = 32'h0;
    slow          = 1'b0;
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_flow();
    t_addr();
    t_alu();
    t_call();
    t_modes();
    t_clocks(1'b0, 64 / CPU_DIV);
    t_clocks(1'b1, 64 / OUT_DIV_SLOW);
    complete_run();
  end
endmodule
`default_nettype wire

// *** sim/ext_memory_model.sv ***
// External memory on the accumulator data path of the core
`timescale 1ns/100ps
`default_nettype none
module ext_memory_model (
  // Clock
  input  wire logic        core_clk_i,
  // Memory side of the core
  input  wire logic [15:0] mem_addr_i,
  input  wire logic [7:0]  mem_wdata_i,
  input  wire logic        mem_we_i,
  output logic [7:0]       ext_data_o
);
  logic [7:0] mem_q [65536];

  // Fill with an address pattern so stale values never look like data
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem_q[i] = i[7:0] ^ 8'ha5;
    end
  end

  // Byte writes come from the accumulator only
  always_ff @(posedge core_clk_i) begin
    if (mem_we_i === 1'b1) begin
      mem_q[mem_addr_i] <= mem_wdata_i;
    end
  end

  // Read data on the same clock as the address
  assign ext_data_o = mem_q[mem_addr_i];
endmodule
`default_nettype wire
